// >>> inc/ecs_pkg.sv
package ecs_pkg;
    localparam int CH_COUNT    = 8;
    localparam int SLOT_W      = 4;
    localparam int CHAN_W      = 3;
    localparam int ADDR_W      = 10;
    localparam int SLOT_SCALE  = 100;
    localparam logic [7:0] STATE_RESET = 8'h00;
    localparam logic [7:0] ALL_OPEN    = 8'h00;
    localparam logic [7:0] ALL_CLOSED  = 8'hFF;
    localparam logic       CH_CLOSED   = 1'b1;
    localparam logic       CH_OPEN     = 1'b0;

    typedef enum logic [2:0] {
        ECS_OP_NONE          = 3'h0,
        ECS_OP_CLOSE_LIST    = 3'h1,
        ECS_OP_OPEN_LIST     = 3'h2,
        ECS_OP_SINGLE_WRITE  = 3'h3,
        ECS_OP_CLOSE_QUERY   = 3'h4,
        ECS_OP_SLOT_WRITE    = 3'h5,
        ECS_OP_SLOT_READ     = 3'h6,
        ECS_OP_RESET         = 3'h7
    } ecs_op_e;

    localparam logic [2:0] OP_IDENTITY_QUERY = 3'h0;
endpackage : ecs_pkg

// >>> verilog/ecs_addr_decode.sv
`timescale 1ns/100ps
// splits a combined channel address (slot*100 + channel) into its parts
module ecs_addr_decode #(
    parameter int ADDR_W = 10,
    parameter int SLOT_W = 4,
    parameter int CHAN_W = 3
) (
    input  wire logic [ADDR_W-1:0] addr,
    output logic      [SLOT_W-1:0] slot,
    output logic      [CHAN_W-1:0] chan,
    output logic                   chan_ok
);
    logic [ADDR_W-1:0] q;
    logic [ADDR_W-1:0] rem;

    always_comb begin
        q       = ADDR_W'(addr / ADDR_W'(ecs_pkg::SLOT_SCALE));
        rem     = ADDR_W'(addr - ADDR_W'(q * ADDR_W'(ecs_pkg::SLOT_SCALE)));
        slot    = SLOT_W'(q);
        chan    = CHAN_W'(rem);
        // channel numbers above 7 do not exist on this card
        chan_ok = (rem < ADDR_W'(ecs_pkg::CH_COUNT));
    end
endmodule : ecs_addr_decode

// >>> verilog/ecs_state_reg.sv
`timescale 1ns/100ps
// How it works
// R1: eight channel state bits are held, each programmable on its own.
// R2: a channel address is slot times one hundred plus channel number.
// R3: a close-list entry sets the addressed bit and leaves the others alone.
// R4: a close query answers one value per listed channel in order, 1 closed, 0 open.
// R5: an open-list entry clears the addressed bit, and lists may name other slots.
// R6: a single-channel write loads the given value into the addressed bit only.
// R7: the controller checks the identity before programming and skips on a mismatch.
// R8: the controller keeps switching slow, about two operations a minute; the logic has no rate limit and the testbench sends entries back to back.
// R9: channel 0 is the least significant bit and channel 7 the most significant.
// R10: a 1 closes a channel and a 0 opens it, so the byte runs from 0 to 255.
// R11: a whole-slot write replaces the byte and a whole-slot read returns it.
// R12: reset or power-on opens every channel by clearing the byte.
module ecs_state_reg #(
    parameter int                         ADDR_W  = ecs_pkg::ADDR_W,
    parameter logic [ecs_pkg::SLOT_W-1:0] MY_SLOT = 4'h1,
    // arbitrary identity value
    parameter logic [23:0]                IDENT   = 24'hA5C3E1
) (
    input  wire logic              CLK,
    input  wire logic              RESETN,
    input  wire logic              CMD_VALID,
    input  wire logic [2:0]        CMD_OP,
    input  wire logic              CMD_IDENT,
    input  wire logic [ADDR_W-1:0] CMD_ADDR,
    input  wire logic [7:0]        CMD_DATA,
    output logic      [7:0]        CH_STATE,
    output logic                   RSP_VALID,
    output logic      [23:0]       RSP_DATA
);
    logic [ecs_pkg::SLOT_W-1:0] dec_slot;
    logic [ecs_pkg::CHAN_W-1:0] dec_chan;
    logic                       dec_ok;
    logic                       hit_ch;
    logic                       hit_slot;
    logic [7:0]                 state_r;
    logic [7:0]                 state_nxt;
    ecs_pkg::ecs_op_e           op;

    ecs_addr_decode #(
        .ADDR_W (ADDR_W),
        .SLOT_W (ecs_pkg::SLOT_W),
        .CHAN_W (ecs_pkg::CHAN_W)
    ) u_dec (
        .addr    (CMD_ADDR),
        .slot    (dec_slot),
        .chan    (dec_chan),
        .chan_ok (dec_ok)
    ); // R2

    assign op = ecs_pkg::ecs_op_e'(CMD_OP);
    // entries for other slots are ignored here, so lists may span slots
    assign hit_slot = CMD_VALID && (dec_slot == MY_SLOT); // R5
    assign hit_ch   = hit_slot && dec_ok;

    always_comb begin
        state_nxt = state_r;
        if (CMD_VALID && !CMD_IDENT) begin
            unique case (op)
                ecs_pkg::ECS_OP_CLOSE_LIST: begin
                    if (hit_ch) state_nxt[dec_chan] = ecs_pkg::CH_CLOSED; // R3 R9 R10
                end
                ecs_pkg::ECS_OP_OPEN_LIST: begin
                    if (hit_ch) state_nxt[dec_chan] = ecs_pkg::CH_OPEN; // R5
                end
                ecs_pkg::ECS_OP_SINGLE_WRITE: begin
                    if (hit_ch) state_nxt[dec_chan] = CMD_DATA[0]; // R6
                end
                ecs_pkg::ECS_OP_SLOT_WRITE: begin
                    if (hit_slot) state_nxt = CMD_DATA; // R11
                end
                ecs_pkg::ECS_OP_RESET: begin
                    if (hit_slot) state_nxt = ecs_pkg::ALL_OPEN; // R12
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) state_r <= ecs_pkg::STATE_RESET; // R12
        else         state_r <= state_nxt; // R1
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) CH_STATE <= ecs_pkg::STATE_RESET;
        else         CH_STATE <= state_nxt;
    end

    // one answer per query entry, so list order is the order of the entries
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            RSP_VALID <= 1'b0;
            RSP_DATA  <= 24'h000000;
        end else begin
            RSP_VALID <= 1'b0;
            RSP_DATA  <= 24'h000000;
            if (CMD_VALID && CMD_IDENT && hit_slot) begin
                RSP_VALID <= 1'b1;
                RSP_DATA  <= IDENT;
            end else if (CMD_VALID && !CMD_IDENT) begin
                if (op == ecs_pkg::ECS_OP_CLOSE_QUERY && hit_ch) begin
                    RSP_VALID <= 1'b1;
                    RSP_DATA  <= {23'h0, state_r[dec_chan]}; // R4
                end else if (op == ecs_pkg::ECS_OP_SLOT_READ && hit_slot) begin
                    RSP_VALID <= 1'b1;
                    RSP_DATA  <= {16'h0000, state_r}; // R11
                end
            end
        end
    end

    a_close_sets_bit: assert property (@(posedge CLK) disable iff (!RESETN) // R3
        (CMD_VALID && !CMD_IDENT && op == ecs_pkg::ECS_OP_CLOSE_LIST && hit_ch)
        |=> CH_STATE[$past(dec_chan)]) else $error("close did not set bit");
    a_open_clears_bit: assert property (@(posedge CLK) disable iff (!RESETN) // R5
        (CMD_VALID && !CMD_IDENT && op == ecs_pkg::ECS_OP_OPEN_LIST && hit_ch)
        |=> !CH_STATE[$past(dec_chan)]) else $error("open did not clear bit");
    a_single_write_bit: assert property (@(posedge CLK) disable iff (!RESETN) // R6
        (CMD_VALID && !CMD_IDENT && op == ecs_pkg::ECS_OP_SINGLE_WRITE && hit_ch)
        |=> ((CH_STATE ^ $past(state_r)) & ~(8'h01 << $past(dec_chan))) == 8'h00)
        else $error("single write touched other bits");
    a_slot_write_byte: assert property (@(posedge CLK) disable iff (!RESETN) // R11
        (CMD_VALID && !CMD_IDENT && op == ecs_pkg::ECS_OP_SLOT_WRITE && hit_slot)
        |=> CH_STATE == $past(CMD_DATA)) else $error("slot write lost");
    a_reset_cmd_open: assert property (@(posedge CLK) disable iff (!RESETN) // R12
        (CMD_VALID && !CMD_IDENT && op == ecs_pkg::ECS_OP_RESET && hit_slot)
        |=> CH_STATE == 8'h00) else $error("reset left channels closed");
    a_query_answer: assert property (@(posedge CLK) disable iff (!RESETN) // R4
        (CMD_VALID && !CMD_IDENT && op == ecs_pkg::ECS_OP_CLOSE_QUERY && hit_ch)
        |=> RSP_VALID && RSP_DATA[0] == $past(state_r[dec_chan]))
        else $error("query answer wrong");
    a_read_answer: assert property (@(posedge CLK) disable iff (!RESETN) // R11
        (CMD_VALID && !CMD_IDENT && op == ecs_pkg::ECS_OP_SLOT_READ && hit_slot)
        |=> RSP_VALID && RSP_DATA[7:0] == $past(state_r)) else $error("read wrong");
    a_idle_holds: assert property (@(posedge CLK) disable iff (!RESETN) // R1
        !CMD_VALID |=> CH_STATE == $past(CH_STATE)) else $error("state moved idle");
    a_other_slot: assert property (@(posedge CLK) disable iff (!RESETN) // R5
        (CMD_VALID && !hit_slot) |=> CH_STATE == $past(CH_STATE) && !RSP_VALID)
        else $error("other slot acted");

    // ops that name one channel rather than the whole slot
    function automatic logic is_chan_op(input logic [2:0] code);
        is_chan_op = (code == ecs_pkg::ECS_OP_CLOSE_LIST)   ||
                     (code == ecs_pkg::ECS_OP_OPEN_LIST)    ||
                     (code == ecs_pkg::ECS_OP_SINGLE_WRITE) ||
                     (code == ecs_pkg::ECS_OP_CLOSE_QUERY);
    endfunction : is_chan_op

    // one accepted entry for a channel of this slot
    sequence s_chan_take(logic [2:0] code);
        CMD_VALID && !CMD_IDENT && CMD_OP == code && is_chan_op(code) && hit_ch;
    endsequence : s_chan_take

    // one accepted entry for the whole slot
    sequence s_slot_take(logic [2:0] code);
        CMD_VALID && !CMD_IDENT && CMD_OP == code && hit_slot;
    endsequence : s_slot_take

    sequence s_ident_take;
        CMD_VALID && CMD_IDENT && hit_slot;
    endsequence : s_ident_take

    // right slot but a channel number this card does not have
    sequence s_chan_refused;
        CMD_VALID && !CMD_IDENT && is_chan_op(CMD_OP) && hit_slot && !dec_ok;
    endsequence : s_chan_refused

    // two query entries back to back, as a list of two
    sequence s_query_two;
        s_chan_take(ecs_pkg::ECS_OP_CLOSE_QUERY)
        ##1 s_chan_take(ecs_pkg::ECS_OP_CLOSE_QUERY);
    endsequence : s_query_two

    a_close_exact: assert property (@(posedge CLK) disable iff (!RESETN) // R9
        s_chan_take(ecs_pkg::ECS_OP_CLOSE_LIST)
        |=> CH_STATE == ($past(state_r) | (8'h01 << $past(dec_chan))))
        else $error("close touched the wrong bit");
    a_open_exact: assert property (@(posedge CLK) disable iff (!RESETN) // R5
        s_chan_take(ecs_pkg::ECS_OP_OPEN_LIST)
        |=> CH_STATE == ($past(state_r) & ~(8'h01 << $past(dec_chan))))
        else $error("open touched the wrong bit");
    a_single_write_val: assert property (@(posedge CLK) disable iff (!RESETN) // R6
        s_chan_take(ecs_pkg::ECS_OP_SINGLE_WRITE)
        |=> CH_STATE[$past(dec_chan)] == $past(CMD_DATA[0]))
        else $error("single write value lost");
    a_query_order: assert property (@(posedge CLK) disable iff (!RESETN) // R4
        s_query_two |-> (RSP_VALID && RSP_DATA[0] == $past(state_r[dec_chan]))
        ##1 (RSP_VALID && RSP_DATA[0] == $past(state_r[dec_chan])))
        else $error("query answers out of order");
    a_query_one_bit: assert property (@(posedge CLK) disable iff (!RESETN) // R4
        s_chan_take(ecs_pkg::ECS_OP_CLOSE_QUERY) |=> RSP_DATA[23:1] == 23'h0)
        else $error("query answer wider than one bit");
    a_query_no_write: assert property (@(posedge CLK) disable iff (!RESETN) // R4
        s_chan_take(ecs_pkg::ECS_OP_CLOSE_QUERY) |=> CH_STATE == $past(CH_STATE))
        else $error("query changed channel state");
    a_read_no_write: assert property (@(posedge CLK) disable iff (!RESETN) // R11
        s_slot_take(ecs_pkg::ECS_OP_SLOT_READ) |=> CH_STATE == $past(CH_STATE))
        else $error("slot read changed channel state");
    a_answer_upper: assert property (@(posedge CLK) disable iff (!RESETN) // R11
        RSP_VALID && !$past(CMD_IDENT) |-> RSP_DATA[23:8] == 16'h0000)
        else $error("state answer has upper bits set");
    a_ident_answer: assert property (@(posedge CLK) disable iff (!RESETN) // R7
        s_ident_take |=> RSP_VALID && RSP_DATA == IDENT)
        else $error("identity answer wrong");
    a_chan_refused: assert property (@(posedge CLK) disable iff (!RESETN) // R1
        s_chan_refused |=> CH_STATE == $past(CH_STATE) && !RSP_VALID)
        else $error("channel above seven acted");
    // a response never appears without an entry behind it
    a_no_cmd_quiet: assert property (@(posedge CLK) disable iff (!RESETN) // R4
        !CMD_VALID |=> !RSP_VALID)
        else $error("answer without a command");
endmodule : ecs_state_reg

// >>> tb/ecs_ctrl_model.sv
`timescale 1ns/100ps
// controller side: one command entry per cycle, driven just after the edge
module ecs_ctrl_model (
    input  wire logic       CLK,
    output logic            CMD_VALID,
    output logic [2:0]      CMD_OP,
    output logic            CMD_IDENT,
    output logic [9:0]      CMD_ADDR,
    output logic [7:0]      CMD_DATA
);
    initial begin
        CMD_VALID = 1'b0;
        CMD_OP    = 3'h0;
        CMD_IDENT = 1'b0;
        CMD_ADDR  = 10'h000;
        CMD_DATA  = 8'h00;
    end
    // real switching pace belongs to controller firmware; entries come back to back
    // here because the logic has no rate limit, and relay wear is not modelled
    task automatic send(input logic [2:0] op, input logic id, input int a, input logic [7:0] d);
        @(posedge CLK);
        CMD_VALID <= 1'b1;
        CMD_OP    <= op;
        CMD_IDENT <= id;
        CMD_ADDR  <= 10'(a);
        CMD_DATA  <= d;
    endtask : send
    // released address and data are inverted so a stale value is never mistaken for a command
    task automatic idle();
        @(posedge CLK);
        CMD_VALID <= 1'b0;
        CMD_ADDR  <= ~CMD_ADDR;
        CMD_DATA  <= ~CMD_DATA;
    endtask : idle
endmodule : ecs_ctrl_model

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(g,e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    // arbitrary identity value
    localparam logic [23:0] ID = 24'h5A3C96;
    localparam logic [2:0]  CL = ecs_pkg::ECS_OP_CLOSE_LIST;
    localparam logic [2:0]  OP = ecs_pkg::ECS_OP_OPEN_LIST;
    localparam logic [2:0]  SW = ecs_pkg::ECS_OP_SINGLE_WRITE;
    localparam logic [2:0]  CQ = ecs_pkg::ECS_OP_CLOSE_QUERY;
    localparam logic [2:0]  WR = ecs_pkg::ECS_OP_SLOT_WRITE;
    localparam logic [2:0]  RD = ecs_pkg::ECS_OP_SLOT_READ;
    localparam logic [2:0]  RS = ecs_pkg::ECS_OP_RESET;
    logic        clk    = 1'b0;
    logic        resetn = 1'b0;
    logic        cmd_valid;
    logic [2:0]  cmd_op;
    logic        cmd_ident;
    logic [9:0]  cmd_addr;
    logic [7:0]  cmd_data;
    logic [7:0]  ch_state;
    logic        rsp_valid;
    logic [23:0] rsp_data;
    int          n_errors = 0;
    int          compares = 0;
    int          cyc      = 0;
    always #5 clk = ~clk;
    ecs_ctrl_model ctl (.CLK(clk), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
        .CMD_IDENT(cmd_ident), .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data));
    // slot 4 so that other-slot entries in a list can be seen being ignored
    ecs_state_reg #(.MY_SLOT(4'h4), .IDENT(ID)) dut (.CLK(clk), .RESETN(resetn),
        .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_IDENT(cmd_ident), .CMD_ADDR(cmd_addr),
        .CMD_DATA(cmd_data), .CH_STATE(ch_state), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));
    task automatic wrap_up();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic done();
        ctl.idle();
        #1;
    endtask : done
    task automatic t_ident();
        ctl.send(3'h0, 1'b1, 400, 8'h00);
        done();
        `CHK(rsp_valid, 1'b1)
        `CHK(rsp_data, ID)
    endtask : t_ident
    task automatic t_slot();
        ctl.send(WR, 1'b0, 400, 8'h6A);
        ctl.send(RD, 1'b0, 400, 8'h00);
        done();
        `CHK(ch_state, 8'h6A)
        `CHK(rsp_data[7:0], 8'h6A)
    endtask : t_slot
    task automatic t_list();
        ctl.send(CL, 1'b0, 402, 8'h00);
        ctl.send(CL, 1'b0, 407, 8'h00);
        ctl.send(CQ, 1'b0, 402, 8'h00);
        ctl.send(CQ, 1'b0, 407, 8'h00);
        #1 `CHK(rsp_data[0], 1'b1)
        ctl.send(CQ, 1'b0, 400, 8'h00);
        #1 `CHK(rsp_data[0], 1'b1)
        done();
        `CHK(rsp_data[0], 1'b0)
        `CHK(ch_state, 8'hEE)
    endtask : t_list
    task automatic t_open();
        ctl.send(OP, 1'b0, 402, 8'h00);
        ctl.send(OP, 1'b0, 305, 8'h00);
        ctl.send(OP, 1'b0, 408, 8'h00);
        ctl.send(OP, 1'b0, 406, 8'h00);
        done();
        `CHK(ch_state, 8'hAA)
    endtask : t_open
    task automatic t_single();
        ctl.send(SW, 1'b0, 403, 8'h00);
        ctl.send(SW, 1'b0, 400, 8'hFF);
        done();
        `CHK(ch_state, 8'hA3)
    endtask : t_single
    task automatic t_rst();
        ctl.send(WR, 1'b0, 400, 8'hFF);
        done();
        `CHK(ch_state, 8'hFF)
        ctl.send(RS, 1'b0, 400, 8'h00);
        done();
        `CHK(ch_state, 8'h00)
        ctl.send(WR, 1'b0, 400, 8'h81);
        done();
        `CHK(ch_state, 8'h81)
        // power-on in mid-run must clear the byte at once
        @(posedge clk);
        resetn <= 1'b0;
        #1 `CHK(ch_state, 8'h00)
        `CHK(rsp_valid, 1'b0)
        @(posedge clk);
        resetn <= 1'b1;
    endtask : t_rst
    task automatic t_refuse();
        ctl.send(CQ, 1'b0, 305, 8'h00);
        ctl.send(CQ, 1'b0, 409, 8'h00);
        #1 `CHK(rsp_valid, 1'b0)
        ctl.send(3'h0, 1'b1, 300, 8'h00);
        #1 `CHK(rsp_valid, 1'b0)
        ctl.send(CL, 1'b0, 409, 8'h00);
        #1 `CHK(rsp_valid, 1'b0)
        done();
        `CHK(ch_state, 8'h00)
        `CHK(rsp_valid, 1'b0)
    endtask : t_refuse
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        #1 `CHK(ch_state, 8'h00)
        t_ident();
        t_slot();
        t_list();
        t_open();
        t_single();
        t_rst();
        t_refuse();
        wrap_up();
    end
endmodule : tb_top
